// ==== src/shrp_defines.svh ====
`ifndef SHRP_DEFINES_SVH
`define SHRP_DEFINES_SVH
// bus addresses, 7-bit
`define SHRP_ADDR_DEFAULT     7'h53
`define SHRP_ADDR_FUSED       7'h52
// register offsets
`define SHRP_REG_STATUS0      8'h00
`define SHRP_REG_STATUS1      8'h01
`define SHRP_REG_DATA_LAST    8'h12
`define SHRP_REG_SET_LAST     8'h37
`define SHRP_REG_INTCFG0      8'h2b
`define SHRP_REG_INTCFG1      8'h2c
`define SHRP_REG_WPTR         8'h38
`define SHRP_REG_RPTR         8'h39
`define SHRP_REG_OVF          8'h3a
`define SHRP_REG_SAMPLE_PORT  8'h3b
// status bit positions
`define SHRP_ST0_LS_NEW       0
`define SHRP_ST0_LS_INT       1
`define SHRP_ST1_PS_NEW       0
`define SHRP_ST1_PS_INT       1
`define SHRP_ST1_BUFFER_ALMOST_FULL_FLAG        4
// interrupt config field positions
`define SHRP_CFG0_LS_EN       0
`define SHRP_CFG1_PS_EN       0
`define SHRP_CFG1_PS_CHANGE   1
`define SHRP_CFG1_BUFFER_ALMOST_FULL_FLAG_EN    4
// clock figures
`define SHRP_CLK_MHZ          125
`define SHRP_HP_CLK_PCT       1
// bit engine counts: data bits per byte, then the ack slot
`define SHRP_BIT_LAST         4'h8
`define SHRP_ACK_SLOT         4'h9
// byte index of the last byte of a sample
`define SHRP_SAMPLE_LAST      2'h2
`endif

// ==== src/shrp_pkg.sv ====
package shrp_pkg;
   // byte port toward the register side
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] data;
   } shrp_byte_type;
   // measurement events from the engines
   typedef struct packed {
      logic ls_new;
      logic ls_thresh;
      logic ps_new;
      logic ps_beyond;
      logic buffer_almost_full_flag;
   } shrp_event_type;
   // link states, one-hot
   typedef enum logic [4:0] {
      SHRP_IDLE  = 5'b00001,
      SHRP_ADDR  = 5'b00010,
      SHRP_WDATA = 5'b00100,
      SHRP_RDATA = 5'b01000,
      SHRP_ACK   = 5'b10000
   } shrp_state_type;
endpackage : shrp_pkg

// ==== src/shrp_i2c_target.sv ====
`timescale 1ns/1ns
`include "shrp_defines.svh"
// byte-level target of the two-wire bus; reports bytes, takes read data
module shrp_i2c_target (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  scl_in,
   input  wire logic                  sda_in,
   output logic                       sda_oe_n,
   input  wire logic                  fuse_addr,
   input  wire logic [7:0]            rd_byte,
   output shrp_pkg::shrp_byte_type    wr_out,
   output logic                       rd_take,
   output logic                       addr_hit,
   output logic                       stop_seen
);
   logic [2:0] scl_sync_reg, scl_sync_next;   // two-stage sync plus history
   logic [2:0] sda_sync_reg, sda_sync_next;
   shrp_pkg::shrp_state_type st_reg, st_next; // link state
   logic [7:0] sh_reg, sh_next;               // shift register
   logic [3:0] cnt_reg, cnt_next;             // bit count
   logic       rd_reg, rd_next;               // current transfer is a read
   logic       oe_reg, oe_next;               // sda pull, low = driving
   logic       nack_reg, nack_next;           // controller refused read byte
   logic [6:0] my_addr;
   logic       scl_rise, scl_fall, start_c, stop_c, scl_s, sda_s;
   // fuse selects one of two addresses
   assign my_addr  = fuse_addr ? `SHRP_ADDR_FUSED : `SHRP_ADDR_DEFAULT;
   assign scl_s    = scl_sync_reg[1];
   assign sda_s    = sda_sync_reg[1];
   assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
   assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
   assign start_c  = scl_s & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
   assign stop_c   = scl_s & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
   assign sda_oe_n = oe_reg;
   // next-state of the bit engine
   always_comb begin
      scl_sync_next = {scl_sync_reg[1:0], scl_in};
      sda_sync_next = {sda_sync_reg[1:0], sda_in};
      st_next    = st_reg;
      sh_next    = sh_reg;
      cnt_next   = cnt_reg;
      rd_next    = rd_reg;
      oe_next    = oe_reg;
      nack_next  = nack_reg;
      wr_out     = '0;
      rd_take    = 1'b0;
      addr_hit   = 1'b0;
      stop_seen  = stop_c;
      if (start_c) begin
         st_next  = shrp_pkg::SHRP_ADDR;
         cnt_next = 4'h0;
         oe_next  = 1'b1;
      end else if (stop_c) begin
         st_next = shrp_pkg::SHRP_IDLE;
         oe_next = 1'b1;
      end else begin
         case (st_reg)
            shrp_pkg::SHRP_IDLE: begin
               oe_next = 1'b1;
            end
            shrp_pkg::SHRP_ADDR, shrp_pkg::SHRP_WDATA: begin
               if (scl_rise) begin
                  sh_next  = {sh_reg[6:0], sda_s};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (scl_fall && cnt_reg == `SHRP_BIT_LAST) begin
                  cnt_next = 4'h0;
                  if (st_reg == shrp_pkg::SHRP_ADDR) begin
                     if (sh_reg[7:1] == my_addr) begin
                        addr_hit   = 1'b1;
                        rd_next    = sh_reg[0];
                        oe_next    = 1'b0;
                        st_next    = shrp_pkg::SHRP_ACK;
                     end else begin
                        st_next = shrp_pkg::SHRP_IDLE;
                     end
                  end else begin
                     wr_out     = '{valid: 1'b1, write: 1'b1, data: sh_reg};
                     oe_next    = 1'b0;
                     st_next    = shrp_pkg::SHRP_ACK;
                  end
               end
            end
            shrp_pkg::SHRP_ACK: begin
               // release after ack clock, then load read byte if reading
               if (scl_fall) begin
                  cnt_next = 4'h0;
                  if (rd_reg) begin
                     sh_next  = rd_byte;
                     oe_next  = rd_byte[7];
                     rd_take  = 1'b1;
                     cnt_next = 4'h1;
                     st_next  = shrp_pkg::SHRP_RDATA;
                  end else begin
                     oe_next = 1'b1;
                     st_next = shrp_pkg::SHRP_WDATA;
                  end
               end
            end
            shrp_pkg::SHRP_RDATA: begin
               if (scl_fall) begin
                  if (cnt_reg == `SHRP_BIT_LAST) begin
                     oe_next = 1'b1;
                     cnt_next = `SHRP_ACK_SLOT;
                  end else if (cnt_reg == `SHRP_ACK_SLOT) begin
                     if (nack_reg) begin
                        st_next = shrp_pkg::SHRP_IDLE;
                     end else begin
                        sh_next  = rd_byte;
                        oe_next  = rd_byte[7];
                        rd_take  = 1'b1;
                        cnt_next = 4'h1;
                     end
                  end else begin
                     sh_next  = {sh_reg[6:0], 1'b0};
                     oe_next  = sh_reg[6];
                     cnt_next = cnt_reg + 4'h1;
                  end
               end
               if (scl_rise && cnt_reg == `SHRP_ACK_SLOT) begin
                  nack_next = sda_s;
               end
            end
            default: st_next = shrp_pkg::SHRP_IDLE;
         endcase
      end
   end
   // registers of the bit engine
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         st_reg       <= shrp_pkg::SHRP_IDLE;
         sh_reg       <= 8'h00;
         cnt_reg      <= 4'h0;
         rd_reg       <= 1'b0;
         oe_reg       <= 1'b1;
         nack_reg     <= 1'b0;
      end else begin
         scl_sync_reg <= scl_sync_next;
         sda_sync_reg <= sda_sync_next;
         st_reg       <= st_next;
         sh_reg       <= sh_next;
         cnt_reg      <= cnt_next;
         rd_reg       <= rd_next;
         oe_reg       <= oe_next;
         nack_reg     <= nack_next;
      end
   end
endmodule : shrp_i2c_target

// ==== src/shrp_register_port.sv ====
`timescale 1ns/1ns
`include "shrp_defines.svh"
// Notes on behaviour
// - answer address 0x53 when fuse clear
// - fused part answers address 0x52
// - pointer advances after every byte, except at the sample port where it holds
// - sample port reads step the ram
// - map split into four regions
// - both status registers clear on read
// - status read also releases interrupt
// - interrupt enables in two config registers
// - proximity interrupt level or change mode
// - interrupt drives the pin low
// - sample read clears almost-full interrupt
// - bio precise clock, sensors loose clock
module shrp_register_port #(
   parameter int RAM_DEPTH = 32                    // sample slots, three bytes each
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  scl_in,      // bus clock pin
   input  wire logic                  sda_in,      // bus data pin, read side
   output logic                       sda_oe_n,    // low pulls data low
   input  wire logic                  fuse_addr,   // one-time address option
   input  shrp_pkg::shrp_event_type   events,      // one-cycle engine events
   input  wire logic [7:0]            wr_ptr,      // sample write pointer
   input  wire logic [7:0]            ovf_cnt,     // overflow count
   input  wire logic [23:0]           ram_word,    // sample at read pointer
   output logic [7:0]                 rd_ptr,      // sample read pointer
   output logic                       irq_n_pin,   // interrupt, active low
   output logic                       bio_clk_sel  // high: precise clock timing
);
   shrp_pkg::shrp_byte_type wr_b;
   logic       rd_take, addr_hit, stop_seen;
   logic [7:0] rd_byte;
   logic [7:0] ptr_reg, ptr_next;                  // register pointer
   logic       ptr_set_reg, ptr_set_next;          // next write byte is pointer
   logic [7:0] st0_reg, st0_next;                  // status first
   logic [7:0] st1_reg, st1_next;                  // status second
   logic [7:0] cfg0_reg, cfg0_next;                // interrupt config first
   logic [7:0] cfg1_reg, cfg1_next;                // interrupt config second
   logic [7:0] set_reg [8'h13:8'h37];              // settings region storage
   logic [7:0] set_next;
   logic [1:0] byte_sel_reg, byte_sel_next;        // byte within sample
   logic [7:0] rdp_reg, rdp_next;                  // read pointer
   logic       ps_prev_reg, ps_prev_next;          // last proximity state
   logic       irq_reg, irq_next;                  // registered pin drive
   logic       ps_hit;
   logic       pend;

   // byte engine on the pins
   shrp_i2c_target u_tgt (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .sda_oe_n  (sda_oe_n),
      .fuse_addr (fuse_addr),
      .rd_byte   (rd_byte),
      .wr_out    (wr_b),
      .rd_take   (rd_take),
      .addr_hit  (addr_hit),
      .stop_seen (stop_seen)
   );

   assign rd_ptr      = rdp_reg;
   assign irq_n_pin   = irq_reg;
   assign bio_clk_sel = 1'b1;    // samples timed from precise clock only

   // read mux over the four regions
   always_comb begin
      rd_byte = 8'h00;
      if (ptr_reg <= `SHRP_REG_DATA_LAST) begin
         if (ptr_reg == `SHRP_REG_STATUS0) rd_byte = st0_reg;
         if (ptr_reg == `SHRP_REG_STATUS1) rd_byte = st1_reg;
      end else if (ptr_reg <= `SHRP_REG_SET_LAST) begin
         if (ptr_reg == `SHRP_REG_INTCFG0)      rd_byte = cfg0_reg;
         else if (ptr_reg == `SHRP_REG_INTCFG1) rd_byte = cfg1_reg;
         else                                  rd_byte = set_reg[ptr_reg];
      end else if (ptr_reg == `SHRP_REG_WPTR) begin
         rd_byte = wr_ptr;
      end else if (ptr_reg == `SHRP_REG_RPTR) begin
         rd_byte = rdp_reg;
      end else if (ptr_reg == `SHRP_REG_OVF) begin
         rd_byte = ovf_cnt;
      end else if (ptr_reg == `SHRP_REG_SAMPLE_PORT) begin
         // low byte first
         case (byte_sel_reg)
            2'h0:    rd_byte = ram_word[7:0];
            2'h1:    rd_byte = ram_word[15:8];
            default: rd_byte = ram_word[23:16];
         endcase
      end
   end

   // proximity hit in level or change mode
   // change mode only counts a fresh reading, beyond level alone is stale
   assign ps_hit = cfg1_reg[`SHRP_CFG1_PS_CHANGE] ? (events.ps_new & events.ps_beyond & ~ps_prev_reg)
                                                   : (events.ps_new & events.ps_beyond);

   // pointer, status, config next values
   always_comb begin
      ptr_next      = ptr_reg;
      ptr_set_next  = ptr_set_reg;
      st0_next      = st0_reg;
      st1_next      = st1_reg;
      cfg0_next     = cfg0_reg;
      cfg1_next     = cfg1_reg;
      set_next      = 8'h00;
      byte_sel_next = byte_sel_reg;
      rdp_next      = rdp_reg;
      ps_prev_next  = events.ps_new ? events.ps_beyond : ps_prev_reg;
      if (addr_hit) begin
         ptr_set_next  = 1'b1;
         byte_sel_next = 2'h0;
      end
      if (stop_seen) ptr_set_next = 1'b0;
      // reads clear status first so new events below win
      if (rd_take) begin
         if (ptr_reg == `SHRP_REG_STATUS0) st0_next = 8'h00;
         if (ptr_reg == `SHRP_REG_STATUS1) st1_next = 8'h00;
         if (ptr_reg == `SHRP_REG_SAMPLE_PORT) begin
            st1_next[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG] = 1'b0;
            if (byte_sel_reg == `SHRP_SAMPLE_LAST) begin
               byte_sel_next = 2'h0;
               rdp_next = (rdp_reg == 8'(RAM_DEPTH - 1)) ? 8'h00 : rdp_reg + 8'h01;
            end else begin
               byte_sel_next = byte_sel_reg + 2'h1;
            end
         end else begin
            ptr_next = ptr_reg + 8'h01;
         end
      end
      if (wr_b.valid) begin
         if (ptr_set_reg) begin
            ptr_next      = wr_b.data;
            ptr_set_next  = 1'b0;
            byte_sel_next = 2'h0;
         end else begin
            if (ptr_reg == `SHRP_REG_INTCFG0) cfg0_next = wr_b.data;
            if (ptr_reg == `SHRP_REG_INTCFG1) cfg1_next = wr_b.data;
            if (ptr_reg == `SHRP_REG_RPTR)    rdp_next  = wr_b.data;
            set_next = wr_b.data;
            if (ptr_reg != `SHRP_REG_SAMPLE_PORT) ptr_next = ptr_reg + 8'h01;
         end
      end
      // engine events set flags, winning over a same-cycle clear
      if (events.ls_new)    st0_next[`SHRP_ST0_LS_NEW] = 1'b1;
      if (events.ls_thresh) st0_next[`SHRP_ST0_LS_INT] = 1'b1;
      if (events.ps_new)    st1_next[`SHRP_ST1_PS_NEW] = 1'b1;
      if (ps_hit)           st1_next[`SHRP_ST1_PS_INT] = 1'b1;
      if (events.buffer_almost_full_flag)     st1_next[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG]  = 1'b1;
   end

   // enabled pending conditions drive the pin
   always_comb begin
      pend = (st0_reg[`SHRP_ST0_LS_INT] & cfg0_reg[`SHRP_CFG0_LS_EN])
           | (st1_reg[`SHRP_ST1_PS_INT] & cfg1_reg[`SHRP_CFG1_PS_EN])
           | (st1_reg[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG]  & cfg1_reg[`SHRP_CFG1_BUFFER_ALMOST_FULL_FLAG_EN]);
      irq_next = ~pend;
   end

   // settings storage
   always_ff @(posedge ref_clk) begin
      if (wr_b.valid && !ptr_set_reg && ptr_reg > `SHRP_REG_DATA_LAST && ptr_reg <= `SHRP_REG_SET_LAST) begin
         set_reg[ptr_reg] <= set_next;
      end
   end

   // control registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ptr_reg      <= 8'h00;
         ptr_set_reg  <= 1'b0;
         st0_reg      <= 8'h00;
         st1_reg      <= 8'h00;
         cfg0_reg     <= 8'h00;
         cfg1_reg     <= 8'h00;
         byte_sel_reg <= 2'h0;
         rdp_reg      <= 8'h00;
         ps_prev_reg  <= 1'b0;
         irq_reg      <= 1'b1;
      end else begin
         ptr_reg      <= ptr_next;
         ptr_set_reg  <= ptr_set_next;
         st0_reg      <= st0_next;
         st1_reg      <= st1_next;
         cfg0_reg     <= cfg0_next;
         cfg1_reg     <= cfg1_next;
         byte_sel_reg <= byte_sel_next;
         rdp_reg      <= rdp_next;
         ps_prev_reg  <= ps_prev_next;
         irq_reg      <= irq_next;
      end
   end

   // pin follows the enabled almost-full flag one cycle later
   a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st1_reg[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG] && cfg1_reg[`SHRP_CFG1_BUFFER_ALMOST_FULL_FLAG_EN]) |=> !irq_n_pin)
      else $error("irq pin not low with pending almost-full");
   a_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_take && ptr_reg == `SHRP_REG_STATUS0 && !events.ls_new && !events.ls_thresh) |=> st0_reg == 8'h00)
      else $error("status not cleared by read");
   a_ptr_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_take && ptr_reg != `SHRP_REG_SAMPLE_PORT) |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer did not advance");
   a_port_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_take && ptr_reg == `SHRP_REG_SAMPLE_PORT && !wr_b.valid) |=> ptr_reg == `SHRP_REG_SAMPLE_PORT)
      else $error("pointer left sample port");
   a_buffer_almost_full_flag_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_take && ptr_reg == `SHRP_REG_SAMPLE_PORT && !events.buffer_almost_full_flag) |=> !st1_reg[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG])
      else $error("sample read kept almost-full");
   a_irq_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg0_reg == 8'h00 && cfg1_reg == 8'h00) |=> irq_n_pin)
      else $error("irq asserted with all enables off");
   a_event_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
      events.buffer_almost_full_flag |=> st1_reg[`SHRP_ST1_BUFFER_ALMOST_FULL_FLAG])
      else $error("event lost against clear");
   a_ps_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!cfg1_reg[`SHRP_CFG1_PS_CHANGE] && events.ps_new && events.ps_beyond) |=> st1_reg[`SHRP_ST1_PS_INT])
      else $error("level mode proximity flag missing");
   a_ps_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg1_reg[`SHRP_CFG1_PS_CHANGE] && !events.ps_new) |=> !$rose(st1_reg[`SHRP_ST1_PS_INT]))
      else $error("change mode flag set without new reading");
endmodule : shrp_register_port

// ==== verification/shrp_ctl_model.sv ====
`timescale 1ns/1ns
// two-wire bus controller, open drain, moves its pins on falling ref_clk edges
module shrp_ctl_model (
   input  wire logic ref_clk,
   input  wire logic sda_in,    // resolved data wire
   output logic      scl_oe_n,  // low pulls the bus clock low
   output logic      sda_oe_n   // low pulls the bus data low
);
   // both lines released at start
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
   end
   // quarter bit, four ref_clk cycles, keeps each clock phase at eight
   task hw();
      repeat (4) @(negedge ref_clk);
   endtask : hw
   // one bit: data moves mid low phase, sampled at end of high phase
   task bit_x(input logic b, output logic r);
      scl_oe_n = 1'b0;
      hw();
      sda_oe_n = b;
      hw();
      scl_oe_n = 1'b1;
      hw();
      hw();
      r = sda_in;
   endtask : bit_x
   // start or repeated start, data falls while clock high
   task start_c();
      scl_oe_n = 1'b0;
      hw();
      sda_oe_n = 1'b1;
      hw();
      scl_oe_n = 1'b1;
      hw();
      hw();
      sda_oe_n = 1'b0;
      hw();
      hw();
   endtask : start_c
   // stop, data rises while clock high
   task stop_c();
      scl_oe_n = 1'b0;
      hw();
      sda_oe_n = 1'b0;
      hw();
      scl_oe_n = 1'b1;
      hw();
      hw();
      sda_oe_n = 1'b1;
      hw();
      hw();
   endtask : stop_c
   // send a byte msb first, ack high when the target pulled low
   task wr_b(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask : wr_b
   // take a byte msb first; last byte gets no ack, ending the read
   task rd_b(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(last, r);
   endtask : rd_b
endmodule : shrp_ctl_model

// ==== verification/shrp_register_port_test.sv ====
`timescale 1ns/1ns
`include "shrp_defines.svh"
// register port bench, all traffic through the controller model
module shrp_register_port_test;
   logic                     ref_clk;     // 125 mhz
   logic                     rst_n;       // sync reset, active low
   logic                     fuse_addr;   // address option
   shrp_pkg::shrp_event_type events;      // engine event pulses
   logic [7:0]               rd_ptr;      // sample read pointer
   logic                     irq_n_pin;   // interrupt, active low
   logic                     bio_clk_sel; // precise clock select
   logic                     dut_oe_n;    // device data pull
   logic                     scl_oe_n;    // controller clock pull
   logic                     sda_oe_n;    // controller data pull
   logic                     sda;         // resolved data wire
   logic [23:0]              ram_word;    // sample at read pointer
   logic [7:0]               got [0:8];   // bytes of the last burst
   int                       n_errors;
   int                       n_tests;
   // pull-up wire, low if anyone pulls
   assign sda = dut_oe_n & sda_oe_n;
   // sample pattern derived from the pointer so each slot differs
   assign ram_word = {rd_ptr ^ 8'h3c, rd_ptr ^ 8'ha5, rd_ptr ^ 8'h69};
   shrp_register_port i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_oe_n), .sda_in(sda), .sda_oe_n(dut_oe_n),
      .fuse_addr(fuse_addr), .events(events), .wr_ptr(8'h05), .ovf_cnt(8'h02), .ram_word(ram_word),
      .rd_ptr(rd_ptr), .irq_n_pin(irq_n_pin), .bio_clk_sel(bio_clk_sel)
   );
   shrp_ctl_model i_ctl (.ref_clk(ref_clk), .sda_in(sda), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
   // free running clock, 8 ns period
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // compare one value, count and report
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // counts, verdict, end of run
   task end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   // reset for 20 cycles with the chosen fuse level
   task do_reset(input logic f);
      rst_n = 1'b0;
      fuse_addr = f;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge ref_clk);
   endtask : do_reset
   // write header: address then register pointer
   task head(input logic [6:0] a, input logic [7:0] r);
      logic ack;
      i_ctl.start_c();
      i_ctl.wr_b({a, 1'b0}, ack);
      chk("addr ack", {7'h0, ack}, 8'h01);
      i_ctl.wr_b(r, ack);
      chk("pointer ack", {7'h0, ack}, 8'h01);
   endtask : head
   // n data bytes from pointer r upward, low byte first
   task wr_regs(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d, input int n);
      logic ack;
      head(a, r);
      for (int i = 0; i < n; i++) begin
         i_ctl.wr_b(d[8*i +: 8], ack);
         chk("data ack", {7'h0, ack}, 8'h01);
      end
      i_ctl.stop_c();
   endtask : wr_regs
   // pointer write, repeated start, one burst read into got
   task rd_regs(input logic [6:0] a, input logic [7:0] r, input int n);
      logic ack;
      head(a, r);
      i_ctl.start_c();
      i_ctl.wr_b({a, 1'b1}, ack);
      chk("read addr ack", {7'h0, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         i_ctl.rd_b(i == n - 1, got[i]);
      end
      i_ctl.stop_c();
   endtask : rd_regs
   // burst compare, expected bytes listed first byte leftmost
   task exp_b(input string name, input logic [71:0] e, input int n);
      for (int i = 0; i < n; i++) begin
         chk(name, got[i], e[8*(n-1-i) +: 8]);
      end
   endtask : exp_b
   // an address the device must not answer
   task foreign(input logic [6:0] a);
      logic ack;
      i_ctl.start_c();
      i_ctl.wr_b({a, 1'b0}, ack);
      chk("foreign addr ack", {7'h0, ack}, 8'h00);
      i_ctl.stop_c();
   endtask : foreign
   // one-cycle event pulse
   task pulse(input logic [4:0] v);
      @(negedge ref_clk);
      events = shrp_pkg::shrp_event_type'(v);
      @(negedge ref_clk);
      events = '0;
   endtask : pulse
   // bounded wait for the interrupt level, then compare
   task wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq_n_pin !== lvl && k < 40) begin
         @(negedge ref_clk);
         k++;
      end
      chk("irq_n_pin", {7'h0, irq_n_pin}, {7'h0, lvl});
   endtask : wait_irq
   // main sequence
   initial begin
      n_errors = 0;
      n_tests = 0;
      events = '0;
      do_reset(1'b0);
      // default address, two-byte write with auto increment
      wr_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_INTCFG0, 16'h1301, 2);
      foreign(`SHRP_ADDR_FUSED);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_INTCFG0, 2);
      exp_b("config readback", 72'h0113, 2);
      chk("bio clock select", {7'h0, bio_clk_sel}, 8'h01);
      $display("test address done");
      // light event raises, status burst clears
      pulse(5'b11000);
      wait_irq(1'b0);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS0, 2);
      exp_b("status burst", 72'h0300, 2);
      wait_irq(1'b1);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS0, 2);
      exp_b("status reread", 72'h0000, 2);
      // light enable off: flag set, pin stays high
      wr_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_INTCFG0, 16'h0000, 1);
      pulse(5'b11000);
      repeat (40) @(negedge ref_clk);
      chk("irq gated", {7'h0, irq_n_pin}, 8'h01);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS0, 1);
      exp_b("gated status", 72'h03, 1);
      $display("test light done");
      // proximity change mode: second beyond reading gives no interrupt
      pulse(5'b00110);
      wait_irq(1'b0);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS1, 1);
      exp_b("prox first", 72'h03, 1);
      wait_irq(1'b1);
      pulse(5'b00110);
      repeat (40) @(negedge ref_clk);
      chk("irq change mode", {7'h0, irq_n_pin}, 8'h01);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS1, 1);
      exp_b("prox repeat", 72'h01, 1);
      // level mode: every beyond reading interrupts
      wr_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_INTCFG1, 16'h0011, 1);
      pulse(5'b00110);
      wait_irq(1'b0);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_STATUS1, 1);
      exp_b("prox level", 72'h03, 1);
      $display("test proximity done");
      // almost full, cleared by a sample burst from the pointers up
      pulse(5'b00001);
      wait_irq(1'b0);
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_WPTR, 9);
      exp_b("sample burst", 72'h05_00_02_69_a5_3c_68_a4_3d, 9);
      wait_irq(1'b1);
      chk("read pointer", rd_ptr, 8'h02);
      // registers past the port only through a fresh pointer write
      rd_regs(`SHRP_ADDR_DEFAULT, `SHRP_REG_INTCFG1, 1);
      exp_b("after port", 72'h11, 1);
      $display("test sample port done");
      // fused address option
      do_reset(1'b1);
      foreign(`SHRP_ADDR_DEFAULT);
      wr_regs(`SHRP_ADDR_FUSED, `SHRP_REG_INTCFG0, 16'h0005, 1);
      rd_regs(`SHRP_ADDR_FUSED, `SHRP_REG_INTCFG0, 2);
      exp_b("fused readback", 72'h0500, 2);
      $display("test fuse done");
      end_sim();
   end
endmodule : shrp_register_port_test
